// ### hdl/ssw_top.sv
// supply supervisor with reset hold-off, watchdog and power-fail flag
// assumes comparator results and the kick pad decode arrive as pins
`timescale 1ns/1ps
module ssw_top
    import ssw_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
    input  wire logic clk_sys_i,
    input  wire logic sys_rst_i,
    input  wire logic supply_low_i,
    input  wire logic manual_reset_n_i,
    input  wire logic watchdog_kick_i,
    input  wire logic watchdog_kick_float_i,
    input  wire logic power_fail_sense_i,
    output logic      reset_n_o,
    output logic      reset_o,
    output logic      watchdog_alarm_n_o,
    output logic      power_fail_flag_n_o
);

    ssw_core_if core_if ();

    ssw_sync u_sync (
        .clk_sys_i             (clk_sys_i),
        .sys_rst_i             (sys_rst_i),
        .supply_low_i          (supply_low_i),
        .manual_reset_n_i      (manual_reset_n_i),
        .watchdog_kick_i       (watchdog_kick_i),
        .watchdog_kick_float_i (watchdog_kick_float_i),
        .power_fail_sense_i    (power_fail_sense_i),
        .sync                  (core_if.sync_src)
    );

    ssw_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .tk        (core_if.tick_src)
    );

    ////////////////////////////////////////////////////////////////////////
    // reset sequencer

    ssw_rst_state_t   state_q;
    ssw_rst_state_t   state_d;
    logic [CNT_W-1:0] hold_cnt_q;
    logic [CNT_W-1:0] hold_cnt_d;
    logic             reset_n_q;
    logic             reset_n_d;
    logic             reset_q;
    logic             reset_d;
    logic             trigger;

    assign trigger = core_if.supply_low | ~core_if.man_rst_n;

    always_comb begin
        state_d    = state_q;
        hold_cnt_d = hold_cnt_q;
        unique case (state_q)
            SSW_RST_ASSERT: begin
                if (!trigger) begin
                    state_d    = SSW_RST_HOLD;
                    hold_cnt_d = '0;
                end
            end
            SSW_RST_HOLD: begin
                if (trigger) begin
                    state_d = SSW_RST_ASSERT;
                end else if (core_if.tick) begin
                    // same hold after manual release
                    // one extra tick covers the free-running tick phase
                    if (hold_cnt_q == RST_HOLD_TICKS) begin
                        state_d = SSW_RST_RUN;
                    end else begin
                        hold_cnt_d = hold_cnt_q + CNT_W'(1);
                    end
                end
            end
            SSW_RST_RUN: begin
                if (trigger) begin
                    state_d = SSW_RST_ASSERT;
                end
            end
            default: begin
                state_d = SSW_RST_ASSERT;
            end
        endcase
        reset_n_d = (state_d == SSW_RST_RUN);
        reset_d   = ~reset_n_d;
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q    <= SSW_RST_ASSERT;
            hold_cnt_q <= '0;
            reset_n_q  <= 1'b0;
            reset_q    <= 1'b1;
        end else begin
            state_q    <= state_d;
            hold_cnt_q <= hold_cnt_d;
            reset_n_q  <= reset_n_d;
            reset_q    <= reset_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // watchdog

    logic [CNT_W-1:0] wd_cnt_q;
    logic [CNT_W-1:0] wd_cnt_d;
    logic             wd_to_q;
    logic             wd_to_d;
    logic             kick_prev_q;
    logic             kick_prev_d;
    logic             kick_edge;
    logic             wd_clear;
    logic             alarm_n_q;
    logic             alarm_n_d;
    logic             pf_n_q;
    logic             pf_n_d;

    assign kick_edge = core_if.kick ^ kick_prev_q;
    assign wd_clear  = kick_edge | ~reset_n_q | core_if.kick_float;

    always_comb begin
        kick_prev_d = core_if.kick;
        wd_cnt_d    = wd_cnt_q;
        wd_to_d     = wd_to_q;
        if (wd_clear) begin
            wd_cnt_d = '0;
            wd_to_d  = 1'b0;
        end else if (core_if.tick && !wd_to_q) begin
            if (wd_cnt_q == WDOG_TIMEOUT_TICKS) begin
                wd_to_d = 1'b1;
            end else begin
                wd_cnt_d = wd_cnt_q + CNT_W'(1);
            end
        end
        // disabled watchdog leaves only supply low
        alarm_n_d = ~(core_if.supply_low | wd_to_d);
        pf_n_d    = core_if.pf_sense;
    end

    // kick_prev starts at the synchroniser's reset level: no false edge
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wd_cnt_q    <= '0;
            wd_to_q     <= 1'b0;
            kick_prev_q <= SYNC_RST_VAL[SYNC_KICK];
            alarm_n_q   <= 1'b0;
            pf_n_q      <= 1'b1;
        end else begin
            wd_cnt_q    <= wd_cnt_d;
            wd_to_q     <= wd_to_d;
            kick_prev_q <= kick_prev_d;
            alarm_n_q   <= alarm_n_d;
            pf_n_q      <= pf_n_d;
        end
    end

    assign reset_n_o           = reset_n_q;
    assign reset_o             = reset_q;
    assign watchdog_alarm_n_o  = alarm_n_q;
    assign power_fail_flag_n_o = pf_n_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_supply_holds_reset;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        core_if.supply_low |=> !reset_n_o ##1 !reset_n_o;
    endproperty
    a_supply_holds_reset: assert property (p_supply_holds_reset)
        else $error("reset released while supply low");

    property p_hold_length;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        $rose(reset_n_o) |-> $past(state_q) == SSW_RST_HOLD
            && $past(hold_cnt_q) == RST_HOLD_TICKS && $past(core_if.tick);
    endproperty
    a_hold_length: assert property (p_hold_length)
        else $error("reset released before hold-off completed");

    property p_complement;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        reset_o != reset_n_o;
    endproperty
    a_complement: assert property (p_complement)
        else $error("active-high reset not inverse of reset_n");

    property p_manual_reset;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (!core_if.man_rst_n && reset_n_o) |=> !reset_n_o && reset_o;
    endproperty
    a_manual_reset: assert property (p_manual_reset)
        else $error("manual reset did not assert reset");

    property p_manual_release;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        ($rose(core_if.man_rst_n) && !core_if.supply_low) |=>
            state_q == SSW_RST_HOLD && hold_cnt_q == '0 && !reset_n_o;
    endproperty
    a_manual_release: assert property (p_manual_release)
        else $error("manual release did not restart the hold-off");

    property p_timeout_value;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        $rose(wd_to_q) |-> $past(wd_cnt_q) == WDOG_TIMEOUT_TICKS
            && $past(reset_n_q) && !$past(core_if.kick_float);
    endproperty
    a_timeout_value: assert property (p_timeout_value)
        else $error("watchdog timed out at wrong count");

    property p_kick_clears;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        kick_edge |=> wd_cnt_q == '0 && !wd_to_q;
    endproperty
    a_kick_clears: assert property (p_kick_clears)
        else $error("kick edge did not clear watchdog");

    property p_clear_in_reset;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        !reset_n_o |=> wd_cnt_q == '0 && !wd_to_q;
    endproperty
    a_clear_in_reset: assert property (p_clear_in_reset)
        else $error("watchdog counting during reset");

    property p_supply_alarm;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        core_if.supply_low |=> !watchdog_alarm_n_o;
    endproperty
    a_supply_alarm: assert property (p_supply_alarm)
        else $error("alarm high while supply low");

    property p_float_alarm;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        core_if.kick_float |=>
            watchdog_alarm_n_o == !$past(core_if.supply_low);
    endproperty
    a_float_alarm: assert property (p_float_alarm)
        else $error("alarm not tracking supply while disabled");

    property p_no_wd_reset;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        $fell(reset_n_o) |-> $past(trigger);
    endproperty
    a_no_wd_reset: assert property (p_no_wd_reset)
        else $error("reset asserted without supply or manual cause");

    property p_pf_flag;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        ##1 power_fail_flag_n_o == $past(core_if.pf_sense);
    endproperty
    a_pf_flag: assert property (p_pf_flag)
        else $error("power-fail flag not following sense");

    property p_alarm_sticky;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (wd_to_q && !wd_clear) |=> wd_to_q && !watchdog_alarm_n_o;
    endproperty
    a_alarm_sticky: assert property (p_alarm_sticky)
        else $error("alarm released without kick or reset");

    property p_retrigger;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (state_q == SSW_RST_HOLD && trigger) |=>
            state_q == SSW_RST_ASSERT ##1 !reset_n_o;
    endproperty
    a_retrigger: assert property (p_retrigger)
        else $error("retrigger did not restart hold-off");

endmodule

// ### hdl/ssw_pkg.sv
// constants shared by the supply supervisor and watchdog block
// assumes a single 100 MHz system clock and digital comparator results
package ssw_pkg;

    // time base
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned TICK_MS         = 1;
    localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned TICK_CNT_W      = 17;

    // supervisor timing, in milliseconds
    localparam int unsigned RST_HOLD_MS     = 200;
    localparam int unsigned WDOG_TIMEOUT_MS = 1600;

    // tick counts derived from the times above
    localparam int unsigned CNT_W = 11;
    localparam logic [CNT_W-1:0] RST_HOLD_TICKS =
        CNT_W'(RST_HOLD_MS / TICK_MS);
    localparam logic [CNT_W-1:0] WDOG_TIMEOUT_TICKS =
        CNT_W'(WDOG_TIMEOUT_MS / TICK_MS);

    // synchroniser lanes and their safe reset levels
    localparam int unsigned SYNC_W        = 5;
    localparam int unsigned SYNC_SUPPLY   = 0;
    localparam int unsigned SYNC_MAN_N    = 1;
    localparam int unsigned SYNC_KICK     = 2;
    localparam int unsigned SYNC_FLOAT    = 3;
    localparam int unsigned SYNC_PF       = 4;
    localparam logic [SYNC_W-1:0] SYNC_RST_VAL = 5'h1b;

    // reset sequencer, gray along assert -> hold -> run
    typedef enum logic [1:0] {
        SSW_RST_ASSERT = 2'h0,
        SSW_RST_HOLD   = 2'h1,
        SSW_RST_RUN    = 2'h3
    } ssw_rst_state_t;

endpackage

// ### hdl/ssw_core_if.sv
// carrier between the input stage, the tick generator and the core
// assumes all members live in the clk_sys_i domain
`timescale 1ns/1ps
interface ssw_core_if;
    logic supply_low;
    logic man_rst_n;
    logic kick;
    logic kick_float;
    logic pf_sense;
    logic tick;

    modport sync_src (output supply_low, man_rst_n, kick, kick_float,
                      output pf_sense);
    modport tick_src (output tick);
    modport core     (input  supply_low, man_rst_n, kick, kick_float,
                      input  pf_sense, tick);
endinterface

// ### hdl/ssw_sync.sv
// two-flop synchronisers for every pin-level input of the supervisor
// assumes the pins are asynchronous to clk_sys_i
`timescale 1ns/1ps
module ssw_sync
    import ssw_pkg::*;
(
    input  wire logic      clk_sys_i,
    input  wire logic      sys_rst_i,
    input  wire logic      supply_low_i,
    input  wire logic      manual_reset_n_i,
    input  wire logic      watchdog_kick_i,
    input  wire logic      watchdog_kick_float_i,
    input  wire logic      power_fail_sense_i,
    ssw_core_if.sync_src   sync
);

    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] meta_d;
    logic [SYNC_W-1:0] stab_q;
    logic [SYNC_W-1:0] stab_d;

    assign raw[SYNC_SUPPLY] = supply_low_i;
    assign raw[SYNC_MAN_N]  = manual_reset_n_i;
    assign raw[SYNC_KICK]   = watchdog_kick_i;
    assign raw[SYNC_FLOAT]  = watchdog_kick_float_i;
    assign raw[SYNC_PF]     = power_fail_sense_i;

    ////////////////////////////////////////////////////////////////////////
    // pins synchronised first
    always_comb begin
        meta_d = raw;
        stab_d = meta_q;
    end

    // reset levels look like supply low, so reset and alarm start asserted
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_q <= SYNC_RST_VAL;
            stab_q <= SYNC_RST_VAL;
        end else begin
            meta_q <= meta_d;
            stab_q <= stab_d;
        end
    end

    assign sync.supply_low = stab_q[SYNC_SUPPLY];
    assign sync.man_rst_n  = stab_q[SYNC_MAN_N];
    assign sync.kick       = stab_q[SYNC_KICK];
    assign sync.kick_float = stab_q[SYNC_FLOAT];
    assign sync.pf_sense   = stab_q[SYNC_PF];

endmodule

// ### hdl/ssw_tick.sv
// free-running millisecond tick shared by both timeouts
// assumes TICK_CYCLES fits in TICK_CNT_W bits
`timescale 1ns/1ps
module ssw_tick
    import ssw_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
    input  wire logic      clk_sys_i,
    input  wire logic      sys_rst_i,
    ssw_core_if.tick_src   tk
);

    localparam logic [TICK_CNT_W-1:0] TICK_LAST =
        TICK_CNT_W'(TICK_CYCLES - 1);

    logic [TICK_CNT_W-1:0] cnt_q;
    logic [TICK_CNT_W-1:0] cnt_d;
    logic                  tick_q;
    logic                  tick_d;

    ////////////////////////////////////////////////////////////////////////
    // single tick counter
    always_comb begin
        tick_d = (cnt_q == TICK_LAST);
        cnt_d  = tick_d ? '0 : cnt_q + TICK_CNT_W'(1);
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tk.tick = tick_q;

endmodule

// ### sim/ssw_cpu_model.sv
// behavioural model of the supervised processor that drives the kick pin
// assumes clk_i is the supervisor clock and reset_n_i its reset output
`timescale 1ns/1ps
module ssw_cpu_model (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic run_i,
    output logic      kick_o
);
    int unsigned gap_q = 0;

    initial kick_o = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // periodic kick toggle
    // gap stays far below the timeout, so a running model never trips it
    always @(posedge clk_i) begin
        if (!run_i || !reset_n_i) begin
            gap_q <= 0;
        end else if (gap_q == 0) begin
            kick_o <= ~kick_o;
            gap_q  <= 200 + $urandom % 700;
        end else begin
            gap_q <= gap_q - 1;
        end
    end
endmodule

// ### sim/supply_supervisor_watchdog_tb.sv
// self-checking bench for the supply supervisor and watchdog
// assumes ssw_top with a short tick and the processor model on the kick
`timescale 1ns/1ps
module supply_supervisor_watchdog_tb;
    import ssw_pkg::*;

    localparam int TICK  = 10;
    localparam int HOLD  = int'(RST_HOLD_TICKS) * TICK;
    localparam int WDOG  = int'(WDOG_TIMEOUT_TICKS) * TICK;
    localparam int LIMIT = 60000;

    typedef struct {
        int   sig;
        logic v;
        int   lo;
        int   hi;
    } ssw_note_t;

    logic        clk_sys_i;
    logic        sys_rst_i;
    logic        supply_low_i;
    logic        manual_reset_n_i;
    logic        watchdog_kick_float_i;
    logic        power_fail_sense_i;
    logic        kick;
    logic        run;
    logic        mon_on;
    logic        reset_n_o;
    logic        reset_o;
    logic        watchdog_alarm_n_o;
    logic        power_fail_flag_n_o;
    int          cyc = 0;
    int          n_fail = 0;
    int          checked = 0;
    ssw_note_t   q[$];
    string       sig_name[3] = '{"reset_n_o", "watchdog_alarm_n_o",
                                 "power_fail_flag_n_o"};

    ssw_top #(.TICK_CYCLES(TICK)) DUT (
        .clk_sys_i             (clk_sys_i),
        .sys_rst_i             (sys_rst_i),
        .supply_low_i          (supply_low_i),
        .manual_reset_n_i      (manual_reset_n_i),
        .watchdog_kick_i       (kick),
        .watchdog_kick_float_i (watchdog_kick_float_i),
        .power_fail_sense_i    (power_fail_sense_i),
        .reset_n_o             (reset_n_o),
        .reset_o               (reset_o),
        .watchdog_alarm_n_o    (watchdog_alarm_n_o),
        .power_fail_flag_n_o   (power_fail_flag_n_o)
    );

    ssw_cpu_model cpu (
        .clk_i     (clk_sys_i),
        .reset_n_i (reset_n_o),
        .run_i     (run),
        .kick_o    (kick)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////
    task automatic check_val(input string what, input logic exp,
                             input logic got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_time(input string what, input int lo, input int hi,
                              input int got);
        checked++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("wrong value %s cycle expected %0d..%0d seen %0d",
                     what, lo, hi, got);
        end
    endtask

    // note an output edge expected lo..hi cycles from now
    task automatic expect_ev(input int sig, input logic v, input int lo,
                             input int hi);
        q.push_back('{sig, v, cyc + lo, cyc + hi});
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic summarize();
        check_time("pending notes", 0, 0, q.size());
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // every edge on reset_n_o, watchdog_alarm_n_o or power_fail_flag_n_o must match the oldest note, in value and in time
    initial begin
        logic [2:0] prev;
        logic [2:0] now;
        ssw_note_t  n;
        wait (mon_on === 1'b1);
        prev = {power_fail_flag_n_o, watchdog_alarm_n_o, reset_n_o};
        forever begin
            @(posedge clk_sys_i);
            #2;
            now = {power_fail_flag_n_o, watchdog_alarm_n_o, reset_n_o};
            for (int s = 0; s < 3; s++) begin
                if (now[s] !== prev[s]) begin
                    if (q.size() == 0) begin
                        n_fail++;
                        $display("wrong value %s expected no edge seen %b",
                                 sig_name[s], now[s]);
                    end else begin
                        n = q.pop_front();
                        check_val(sig_name[s], n.v,
                                  (n.sig == s) ? now[s] : 1'bx);
                        check_time(sig_name[s], n.lo, n.hi, cyc);
                    end
                end
            end
            prev = now;
        end
    end

    always @(negedge clk_sys_i) begin
        if (mon_on) check_val("reset_o", ~reset_n_o, reset_o);
    end

    always @(posedge clk_sys_i) begin
        if (cyc == LIMIT) begin
            n_fail++;
            $display("wrong value run length expected done seen hang");
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        int k;
        logic v;
        sys_rst_i             = 1'b1;
        supply_low_i          = 1'b0;
        manual_reset_n_i      = 1'b1;
        watchdog_kick_float_i = 1'b0;
        power_fail_sense_i    = 1'b1;
        run                   = 1'b0;
        mon_on                = 1'b0;
        void'($urandom(32'h5aa21e60));
        step(10);
        sys_rst_i = 1'b0;
        mon_on    = 1'b1;
        run       = 1'b1;
        k         = cyc;
        expect_ev(1, 1'b1, 1, 8);
        step(20);
        v = 1'b1;
        for (int i = 0; i < 8; i++) begin
            power_fail_sense_i = (i == 7) ? 1'b1 : 1'($urandom);
            if (power_fail_sense_i !== v)
                expect_ev(2, power_fail_sense_i, 2, 4);
            v = power_fail_sense_i;
            step(5 + $urandom % 16);
        end
        q.push_back('{0, 1'b1, k + HOLD, k + HOLD + 15});
        wait (q.size() == 0);
        step(20);
        $display("test power_up done");

        // manual reset with a retrigger half way through the hold-off
        run              = 1'b0;
        manual_reset_n_i = 1'b0;
        expect_ev(0, 1'b0, 2, 4);
        step(3 + $urandom % 40);
        manual_reset_n_i = 1'b1;
        step(HOLD / 2);
        manual_reset_n_i = 1'b0;
        step(3 + $urandom % 4);
        manual_reset_n_i = 1'b1;
        expect_ev(0, 1'b1, HOLD, HOLD + 15);
        expect_ev(1, 1'b0, HOLD + WDOG, HOLD + WDOG + 40);
        wait (q.size() == 0);
        step(500);
        run = 1'b1;
        expect_ev(1, 1'b1, 2, 6);
        wait (q.size() == 0);
        step(4000);
        $display("test watchdog done");

        // floating kick, then a supply dip
        watchdog_kick_float_i = 1'b1;
        run                   = 1'b0;
        step(WDOG + 1000);
        supply_low_i = 1'b1;
        expect_ev(0, 1'b0, 2, 4);
        expect_ev(1, 1'b0, 2, 4);
        step(100);
        supply_low_i = 1'b0;
        expect_ev(1, 1'b1, 2, 6);
        expect_ev(0, 1'b1, HOLD, HOLD + 15);
        wait (q.size() == 0);
        step(20);
        $display("test supply_low done");
        summarize();
    end
endmodule
